// file: verilog/cff_frame_config_regs.sv
// Frame numbering, frame-sync generator and forwarding configuration register bank
//
// Operation
// R1 - In raw operation each generated frame start and end packet carries a sixteen-bit frame number.
// R2 - A frame count limit of zero disables numbering so every frame number is zero.
// R3 - With a non-zero limit the frame number counts 1 up to the limit and then wraps to 1.
// R4 - The frame count limit is sixteen bits split over two byte registers, lower byte resetting to 4, upper to 0.
// R5 - The sync low period is sixteen bits split over two byte registers, both resetting to zero.
// R6 - A programmed sync period value yields a phase one cycle longer than the value.
// R7 - A two-bit lane rate field selects 1.5/1.6 Gbps, reserved, 800 Mbps or 400 Mbps and resets to 10.
// R8 - Bits 7 to 4 of the forward control register disable forwarding of ports 3 to 0 and reset to one.
// R9 - Bit 3 of the forward control register sends port 3 to output 0 when clear and output 1 when set.
// R10 - Software should disable forwarding of a port before changing its output mapping.
// R11 - In the lane rate register bits 7:3 read zero and bit 2 is a spare writable bit resetting to zero.
// R12 - Separate mode times high and low phases apart; half mode uses one 24-bit value for both phases.
// R13 - Bits 2 to 0 of the forward control register map ports 2 to 0 to output 0 or output 1.
// R14 - Multi-byte counts are captured whole at reload so a half-written pair never acts mid-period.
`timescale 1ns/1ps
module cff_frame_config_regs (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic frame_start,
	output logic [15:0] frame_number,
	output logic camera_sync_pulse,
	output logic [1:0] lane_rate,
	output logic [3:0] forward_off,
	output logic [3:0] output_select
);
	logic [7:0] fsync_low_upper_field, next_fsync_low_upper_field;
	logic [7:0] fsync_low_lower_field, next_fsync_low_lower_field;
	logic [7:0] frame_limit_upper_field, next_frame_limit_upper_field;
	logic [7:0] frame_limit_lower_field, next_frame_limit_lower_field;
	logic [1:0] rate, next_rate;
	logic lane_spare, next_lane_spare;
	logic [3:0] fwd_off, next_fwd_off;
	logic [3:0] out_sel, next_out_sel;
	logic [7:0] fsync_ctl, next_fsync_ctl;
	logic [7:0] fsync_high_upper, next_fsync_high_upper;
	logic [7:0] fsync_high_lower, next_fsync_high_lower;
	logic [7:0] rdata, next_rdata;

	// Frame counter state
	logic [15:0] frame_num, next_frame_num;

	// Generator state
	logic sync_level, next_sync_level;
	logic [23:0] phase_count, next_phase_count;
	logic [23:0] phase_load;
	logic gen_run, next_gen_run;

	logic [15:0] low_period;
	logic [15:0] high_period;
	logic [15:0] limit_prog;
	logic [23:0] half_period;

	assign low_period = {fsync_low_upper_field, fsync_low_lower_field}; // R5
	assign high_period = {fsync_high_upper, fsync_high_lower};
	assign limit_prog = {frame_limit_upper_field, frame_limit_lower_field}; // R4
	assign half_period = {fsync_high_lower, fsync_low_upper_field, fsync_low_lower_field};

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	// Register writes and read mux
	always_comb begin
		next_fsync_low_upper_field = fsync_low_upper_field;
		next_fsync_low_lower_field = fsync_low_lower_field;
		next_frame_limit_upper_field = frame_limit_upper_field;
		next_frame_limit_lower_field = frame_limit_lower_field;
		next_rate = rate;
		next_lane_spare = lane_spare;
		next_fwd_off = fwd_off;
		next_out_sel = out_sel;
		next_fsync_ctl = fsync_ctl;
		next_fsync_high_upper = fsync_high_upper;
		next_fsync_high_lower = fsync_high_lower;
		next_rdata = 8'h00;
		if (reg_wr) begin
			if (hit(reg_addr, cff_pkg::ADDR_FSYNC_LOW_UPPER)) begin
				next_fsync_low_upper_field = reg_wdata; // R5
			end
			if (hit(reg_addr, cff_pkg::ADDR_FSYNC_LOW_LOWER)) begin
				next_fsync_low_lower_field = reg_wdata; // R5
			end
			if (hit(reg_addr, cff_pkg::ADDR_FRAME_LIMIT_UPPER)) begin
				next_frame_limit_upper_field = reg_wdata; // R4
			end
			if (hit(reg_addr, cff_pkg::ADDR_FRAME_LIMIT_LOWER)) begin
				next_frame_limit_lower_field = reg_wdata; // R4
			end
			if (hit(reg_addr, cff_pkg::ADDR_LANE_RATE_SELECT)) begin
				next_rate = reg_wdata[1:0]; // R7
				next_lane_spare = reg_wdata[cff_pkg::LANE_SPARE_BIT]; // R11
			end
			if (hit(reg_addr, cff_pkg::ADDR_PORT_FORWARD_CONTROL)) begin
				next_fwd_off = reg_wdata[7:4]; // R8
				next_out_sel = reg_wdata[3:0]; // R9 R13
			end
			if (hit(reg_addr, cff_pkg::ADDR_FSYNC_CONTROL)) begin
				next_fsync_ctl = reg_wdata;
			end
			if (hit(reg_addr, cff_pkg::ADDR_FSYNC_HIGH_UPPER)) begin
				next_fsync_high_upper = reg_wdata;
			end
			if (hit(reg_addr, cff_pkg::ADDR_FSYNC_HIGH_LOWER)) begin
				next_fsync_high_lower = reg_wdata;
			end
		end
		if (reg_rd) begin
			unique case (reg_addr)
				cff_pkg::ADDR_FSYNC_LOW_UPPER: next_rdata = fsync_low_upper_field;
				cff_pkg::ADDR_FSYNC_LOW_LOWER: next_rdata = fsync_low_lower_field;
				cff_pkg::ADDR_FRAME_LIMIT_UPPER: next_rdata = frame_limit_upper_field;
				cff_pkg::ADDR_FRAME_LIMIT_LOWER: next_rdata = frame_limit_lower_field;
				cff_pkg::ADDR_LANE_RATE_SELECT: next_rdata = {5'h00, lane_spare, rate}; // R11
				cff_pkg::ADDR_PORT_FORWARD_CONTROL: next_rdata = {fwd_off, out_sel};
				cff_pkg::ADDR_FSYNC_CONTROL: next_rdata = fsync_ctl;
				cff_pkg::ADDR_FSYNC_HIGH_UPPER: next_rdata = fsync_high_upper;
				cff_pkg::ADDR_FSYNC_HIGH_LOWER: next_rdata = fsync_high_lower;
				cff_pkg::ADDR_FRAME_NUMBER_UPPER: next_rdata = frame_num[15:8];
				cff_pkg::ADDR_FRAME_NUMBER_LOWER: next_rdata = frame_num[7:0];
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fsync_low_upper_field <= cff_pkg::RST_FSYNC_LOW;
			fsync_low_lower_field <= cff_pkg::RST_FSYNC_LOW;
			frame_limit_upper_field <= cff_pkg::RST_FRAME_LIMIT_UPPER;
			frame_limit_lower_field <= cff_pkg::RST_FRAME_LIMIT_LOWER;
			rate <= cff_pkg::RST_LANE_RATE;
			lane_spare <= cff_pkg::RST_LANE_SPARE;
			fwd_off <= cff_pkg::RST_FORWARD_OFF;
			out_sel <= cff_pkg::RST_OUTPUT_SELECT;
			fsync_ctl <= cff_pkg::RST_FSYNC_CONTROL;
			fsync_high_upper <= cff_pkg::RST_FSYNC_HIGH;
			fsync_high_lower <= cff_pkg::RST_FSYNC_HIGH;
			rdata <= 8'h00;
		end else if (clk_en) begin
			fsync_low_upper_field <= next_fsync_low_upper_field;
			fsync_low_lower_field <= next_fsync_low_lower_field;
			frame_limit_upper_field <= next_frame_limit_upper_field;
			frame_limit_lower_field <= next_frame_limit_lower_field;
			rate <= next_rate;
			lane_spare <= next_lane_spare;
			fwd_off <= next_fwd_off;
			out_sel <= next_out_sel;
			fsync_ctl <= next_fsync_ctl;
			fsync_high_upper <= next_fsync_high_upper;
			fsync_high_lower <= next_fsync_high_lower;
			rdata <= next_rdata;
		end
	end

	assign reg_rdata = rdata;
	assign lane_rate = rate;
	assign forward_off = fwd_off;
	assign output_select = out_sel;

	// Frame numbering; the limit is read only on a frame start so byte writes between frames never tear it
	always_comb begin
		next_frame_num = frame_num;
		if (frame_start) begin
			if (limit_prog == 16'h0000) begin // R14
				next_frame_num = 16'h0000; // R2
			end else if (frame_num >= limit_prog || frame_num == 16'h0000) begin
				next_frame_num = 16'h0001; // R3
			end else begin
				next_frame_num = frame_num + 16'h0001; // R3
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			frame_num <= cff_pkg::RST_FRAME_NUMBER;
		end else if (clk_en) begin
			frame_num <= next_frame_num;
		end
	end

	assign frame_number = frame_num; // R1

	// Sync generator; each phase after the first following enable lasts its programmed value plus one cycle
	always_comb begin
		phase_load = 24'h000000;
		if (fsync_ctl[cff_pkg::FSYNC_PATTERN_BIT]) begin
			phase_load = half_period; // R12
		end else if (sync_level) begin
			phase_load = {8'h00, low_period}; // R12
		end else begin
			phase_load = {8'h00, high_period}; // R12
		end
		next_sync_level = sync_level;
		next_phase_count = phase_count;
		next_gen_run = fsync_ctl[cff_pkg::FSYNC_ENABLE_BIT];
		if (!fsync_ctl[cff_pkg::FSYNC_ENABLE_BIT]) begin
			next_sync_level = fsync_ctl[cff_pkg::FSYNC_INIT_BIT];
			next_phase_count = 24'h000000;
		end else if (!gen_run) begin
			next_phase_count = fsync_ctl[cff_pkg::FSYNC_PATTERN_BIT] ? half_period
				: (sync_level ? {8'h00, high_period} : {8'h00, low_period}); // R14
		end else if (phase_count == 24'h000000) begin
			next_sync_level = !sync_level;
			next_phase_count = phase_load; // R6 R14
		end else begin
			next_phase_count = phase_count - 24'h000001; // R6
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync_level <= 1'b0;
			phase_count <= 24'h000000;
			gen_run <= 1'b0;
		end else if (clk_en) begin
			sync_level <= next_sync_level;
			phase_count <= next_phase_count;
			gen_run <= next_gen_run;
		end
	end

	assign camera_sync_pulse = sync_level;

	property p_zero_limit;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && frame_start && limit_prog == 16'h0000) |=> (frame_number == 16'h0000);
	endproperty
	a_zero_limit: assert property (p_zero_limit) else $error("Frame number not zero with zero limit"); // R2

	property p_wrap;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && frame_start && limit_prog != 16'h0000 && frame_num >= limit_prog) |=> (frame_number == 16'h0001);
	endproperty
	a_wrap: assert property (p_wrap) else $error("Frame number did not wrap to one"); // R3

	property p_step;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && frame_start && frame_num != 16'h0000 && frame_num < limit_prog)
			|=> (frame_number == $past(frame_num) + 16'h0001);
	endproperty
	a_step: assert property (p_step) else $error("Frame number did not advance by one"); // R3

	property p_hold;
		@(posedge clock) disable iff (!rst_b)
		(!frame_start || !clk_en) |=> $stable(frame_number);
	endproperty
	a_hold: assert property (p_hold) else $error("Frame number moved without frame start"); // R1

	property p_rate_reserved;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && reg_rd && reg_addr == cff_pkg::ADDR_LANE_RATE_SELECT) |=> (reg_rdata[7:3] == 5'h00);
	endproperty
	a_rate_reserved: assert property (p_rate_reserved) else $error("Reserved rate bits not zero"); // R11

	property p_fwd_write;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && reg_wr && reg_addr == cff_pkg::ADDR_PORT_FORWARD_CONTROL)
			|=> (forward_off == $past(reg_wdata[7:4]) && output_select == $past(reg_wdata[3:0]));
	endproperty
	a_fwd_write: assert property (p_fwd_write) else $error("Forward control write not applied"); // R8

	property p_rate_write;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && reg_wr && reg_addr == cff_pkg::ADDR_LANE_RATE_SELECT) |=> (lane_rate == $past(reg_wdata[1:0]));
	endproperty
	a_rate_write: assert property (p_rate_write) else $error("Lane rate write not applied"); // R7

	property p_zero_period;
		@(posedge clock) disable iff (!rst_b)
		(clk_en && gen_run && fsync_ctl[cff_pkg::FSYNC_ENABLE_BIT] && phase_count == 24'h000000)
			|=> (camera_sync_pulse != $past(camera_sync_pulse));
	endproperty
	a_zero_period: assert property (p_zero_period) else $error("Sync phase did not end at count zero"); // R6
endmodule

// file: verilog/cff_pkg.sv
// Package with register map, reset values and encodings of the frame configuration bank
package cff_pkg;
	localparam logic [7:0] ADDR_FSYNC_LOW_UPPER = 8'h1b;
	localparam logic [7:0] ADDR_FSYNC_LOW_LOWER = 8'h1c;
	localparam logic [7:0] ADDR_FRAME_LIMIT_UPPER = 8'h1d;
	localparam logic [7:0] ADDR_FRAME_LIMIT_LOWER = 8'h1e;
	localparam logic [7:0] ADDR_LANE_RATE_SELECT = 8'h1f;
	localparam logic [7:0] ADDR_PORT_FORWARD_CONTROL = 8'h20;
	localparam logic [7:0] ADDR_FSYNC_CONTROL = 8'h21;
	localparam logic [7:0] ADDR_FSYNC_HIGH_UPPER = 8'h22;
	localparam logic [7:0] ADDR_FSYNC_HIGH_LOWER = 8'h23;
	localparam logic [7:0] ADDR_FRAME_NUMBER_UPPER = 8'h24;
	localparam logic [7:0] ADDR_FRAME_NUMBER_LOWER = 8'h25;

	localparam logic [7:0] RST_FSYNC_LOW = 8'h00;
	localparam logic [7:0] RST_FRAME_LIMIT_UPPER = 8'h00;
	localparam logic [7:0] RST_FRAME_LIMIT_LOWER = 8'h04;
	localparam logic [1:0] RST_LANE_RATE = 2'h2;
	localparam logic RST_LANE_SPARE = 1'b0;
	localparam logic [3:0] RST_FORWARD_OFF = 4'hf;
	localparam logic [3:0] RST_OUTPUT_SELECT = 4'h0;
	localparam logic [7:0] RST_FSYNC_CONTROL = 8'h00;
	localparam logic [7:0] RST_FSYNC_HIGH = 8'h00;
	localparam logic [15:0] RST_FRAME_NUMBER = 16'h0000;

	localparam int LANE_SPARE_BIT = 2;
	localparam int FORWARD_OFF_LSB = 4;
	localparam int FSYNC_ENABLE_BIT = 0;
	localparam int FSYNC_PATTERN_BIT = 1;
	localparam int FSYNC_INIT_BIT = 2;

	typedef enum logic [1:0] {
		CFF_RATE_FAST = 2'h0,
		CFF_RATE_RESERVED = 2'h1,
		CFF_RATE_800M = 2'h2,
		CFF_RATE_400M = 2'h3
	} cff_rate_e;
endpackage

// file: verification/cff_frame_config_regs_test.sv
// Self-checking bench of the frame configuration register bank
`timescale 1ns/1ps
module cff_frame_config_regs_test;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic frame_start = 1'b0;
	logic [7:0] reg_rdata;
	logic [15:0] frame_number;
	logic camera_sync_pulse;
	logic [1:0] lane_rate;
	logic [3:0] forward_off;
	logic [3:0] output_select;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	integer seed = 6;
	logic [15:0] num = 16'h0000;
	logic [15:0] lim;
	logic [7:0] d;
	logic [7:0] a;
	logic [7:0] addrs [6] = '{8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20};

	cff_frame_config_regs dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.frame_start(frame_start), .frame_number(frame_number), .camera_sync_pulse(camera_sync_pulse),
		.lane_rate(lane_rate), .forward_off(forward_off), .output_select(output_select));

	always #2 clock = ~clock;

	// The whole run needs under two thousand cycles; the ceiling leaves ample margin
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] da);
		@(posedge clock);
		reg_addr <= ad;
		reg_wdata <= da;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("rdata@%h", ad), {8'h00, exp}, {8'h00, reg_rdata});
	endtask

	function automatic logic [15:0] next_num(input logic [15:0] cur, input logic [15:0] top);
		if (top == 16'h0000)
			return 16'h0000;
		if (cur >= top)
			return 16'h0001;
		return cur + 16'h0001;
	endfunction

	task automatic frame();
		@(posedge clock);
		frame_start <= 1'b1;
		@(posedge clock);
		frame_start <= 1'b0;
		#1;
		num = next_num(num, lim);
		chk("frame_number", num, frame_number);
	endtask

	task automatic wait_lvl(input logic lv, output int n);
		n = 0;
		while (camera_sync_pulse === lv && n < 600) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask

	// The first phase after enable holds an extra load cycle, so measure only later phases
	task automatic sync_case(input logic [15:0] low, input logic [7:0] high, input logic mode, input int elo,
		input int ehi);
		int n;
		wr(8'h21, 8'h00);
		wr(8'h1b, low[15:8]);
		wr(8'h1c, low[7:0]);
		wr(8'h22, 8'h00);
		wr(8'h23, high);
		wr(8'h21, {6'h00, mode, 1'b1});
		wait_lvl(1'b0, n);
		wait_lvl(1'b1, n);
		wait_lvl(1'b0, n);
		chk("sync low", 16'(elo), 16'(n));
		wait_lvl(1'b1, n);
		chk("sync high", 16'(ehi), 16'(n));
	endtask

	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		#1;
		chk("lane_rate", 16'h0002, {14'h0, lane_rate});
		chk("forward_off", 16'h000f, {12'h0, forward_off});
		chk("output_select", 16'h0000, {12'h0, output_select});
		chk("frame_number", 16'h0000, frame_number);
		rdchk(8'h1b, 8'h00);
		rdchk(8'h1c, 8'h00);
		rdchk(8'h1d, 8'h00);
		rdchk(8'h1e, 8'h04);
		rdchk(8'h1f, 8'h02);
		rdchk(8'h20, 8'hf0);
		@(posedge clock);
		#1;
		chk("rdata idle", 16'h0000, {8'h00, reg_rdata});
		wr(8'h80, 8'hff);
		rdchk(8'h80, 8'h00);
		$display("test reset done");
		for (int r = 0; r < 4; r++) begin
			wr(8'h1f, {5'h1f, r[0], r[1:0]});
			chk("lane_rate", 16'(r), {14'h0, lane_rate});
			rdchk(8'h1f, {5'h00, r[0], r[1:0]});
		end
		repeat (24) begin
			a = addrs[$unsigned($random(seed)) % 6];
			d = 8'($random(seed));
			wr(a, d);
			rdchk(a, (a == 8'h1f) ? (d & 8'h07) : d);
			if (a == 8'h20) begin
				chk("forward_off", {12'h0, d[7:4]}, {12'h0, forward_off});
				chk("output_select", {12'h0, d[3:0]}, {12'h0, output_select});
			end
		end
		wr(8'h20, 8'hf0);
		wr(8'h20, 8'hf8);
		wr(8'h20, 8'h78);
		chk("forward_off", 16'h0007, {12'h0, forward_off});
		chk("output_select", 16'h0008, {12'h0, output_select});
		@(posedge clock);
		clk_en <= 1'b0;
		wr(8'h20, 8'h00);
		@(posedge clock);
		clk_en <= 1'b1;
		rdchk(8'h20, 8'h78);
		$display("test registers done");
		wr(8'h1d, 8'h00);
		wr(8'h1e, 8'h03);
		lim = 16'h0003;
		repeat (5) frame();
		wr(8'h1e, 8'h00);
		lim = 16'h0000;
		repeat (2) frame();
		wr(8'h1d, 8'h01);
		wr(8'h1e, 8'h02);
		lim = 16'h0102;
		repeat (3) frame();
		wr(8'h1d, 8'h00);
		wr(8'h1e, 8'h01);
		lim = 16'h0001;
		repeat (2) frame();
		rdchk(8'h24, num[15:8]);
		rdchk(8'h25, num[7:0]);
		$display("test frames done");
		sync_case(16'h0002, 8'h01, 1'b0, 3, 2);
		sync_case(16'h0000, 8'h00, 1'b0, 1, 1);
		sync_case(16'h0001, 8'h00, 1'b1, 2, 2);
		sync_case(16'h0100, 8'h00, 1'b1, 257, 257);
		wr(8'h21, 8'h04);
		// The level follows the control byte one edge after the write lands
		@(posedge clock);
		#1;
		chk("sync init", 16'h0001, {15'h0, camera_sync_pulse});
		wr(8'h21, 8'h00);
		@(posedge clock);
		#1;
		chk("sync init", 16'h0000, {15'h0, camera_sync_pulse});
		$display("test sync done");
		tally_and_finish();
	end
endmodule
